/* ctpil_defines.vh */
// constants for the character tape image loader host
`ifndef CTPIL_DEFINES_VH
`define CTPIL_DEFINES_VH
// character codes
`define CTPIL_CH_START     7'h42
`define CTPIL_CH_FINISH    7'h46
`define CTPIL_CH_HIGH      7'h50
`define CTPIL_CH_LOW       7'h4E
`define CTPIL_CH_RUBOUT    7'h7F
// memory image shape
`define CTPIL_WORDS        13'h1000
`define CTPIL_ADDR_W       12
`define CTPIL_DATA_W       4
`define CTPIL_BITS_PER_WORD 3'h4
// leader and trailer length
`define CTPIL_MIN_RUBOUTS  5'h19
`endif

/* ctpil_loader.v */
// tape parser and asynchronous-style read port for a 4096 x 4 memory image
// What this block does
// R1 - the source opens the stream with at least 25 rubouts, taken as filler.
// R2 - all 4096 words arrive in order from word zero and fill consecutive addresses.
// R3 - before a word, every character except word-start is ignored.
// R4 - a word-start character opens collection of a new word.
// R5 - a word holds exactly four level characters, first one to the top bit.
// R6 - word-finish closes the word and commits its four bits to the image.
// R7 - after a word, comment text and line ends are skipped until the next word-start.
// R8 - the source closes the stream with at least 25 rubouts.
// R9 - the high-level character stores one, the low-level character stores zero.
// R10 - any other character inside a word is a format violation.
// R11 - rubouts inside a word discard the partial word, which is retyped from word-start.
// R12 - a transmitted stream carries even parity on every character.
// R13 - with both selects low the word at the address drives the outputs.
// R14 - with either select high the outputs float.
// R15 - unprogrammed bits read zero and programming only sets bits.
// R16 - format violations and a wrong word count at the trailer raise an error flag.
// R17 - even parity may be checked per character and flagged.
`include "ctpil_defines.vh"
module ctpil_loader
(
   // clock and reset
   input  wire                       core_clk,
   input  wire                       rst,
   // character source
   input  wire [7:0]                 char_data,
   input  wire                       char_valid,
   input  wire                       parity_check_en,
   // memory read port
   input  wire [`CTPIL_ADDR_W-1:0]   word_address_lines,
   input  wire                       chip_select_first_low,
   input  wire                       chip_select_second_low,
   output reg  [`CTPIL_DATA_W-1:0]   memory_outputs,
   output reg  [`CTPIL_DATA_W-1:0]   memory_outputs_oe,
   // status
   output reg                        load_done,
   output reg                        format_error,
   output reg                        count_error,
   output reg                        parity_error,
   output reg  [12:0]                words_loaded
);
   // states, one-hot
   localparam [2:0] S_SEEK = 3'b001;
   localparam [2:0] S_WORD = 3'b010;
   localparam [2:0] S_DONE = 3'b100;

   // is the character a level character
   function is_level;
      input [6:0] c;
      begin
         is_level = (c == `CTPIL_CH_HIGH) || (c == `CTPIL_CH_LOW);
      end
   endfunction

   // ==========================================
   // input synchronisers
   reg [7:0] chr_s1_q;
   reg [7:0] chr_s2_q;
   reg       vld_s1_q;
   reg       vld_s2_q;
   reg       vld_s3_q;
   reg       par_s1_q;
   reg       par_s2_q;
   reg [1:0] cs_s1_q;
   reg [1:0] cs_s2_q;
   reg [`CTPIL_ADDR_W-1:0] adr_s1_q;
   reg [`CTPIL_ADDR_W-1:0] adr_s2_q;

   // two flops on every pin, plus one for the strobe edge
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         chr_s1_q <= 8'h00;
         chr_s2_q <= 8'h00;
         vld_s1_q <= 1'b0;
         vld_s2_q <= 1'b0;
         vld_s3_q <= 1'b0;
         par_s1_q <= 1'b0;
         par_s2_q <= 1'b0;
         cs_s1_q  <= 2'h3;
         cs_s2_q  <= 2'h3;
         adr_s1_q <= 12'h000;
         adr_s2_q <= 12'h000;
      end
      else
      begin
         chr_s1_q <= char_data;
         chr_s2_q <= chr_s1_q;
         vld_s1_q <= char_valid;
         vld_s2_q <= vld_s1_q;
         vld_s3_q <= vld_s2_q;
         par_s1_q <= parity_check_en;
         par_s2_q <= par_s1_q;
         cs_s1_q  <= {chip_select_second_low, chip_select_first_low};
         cs_s2_q  <= cs_s1_q;
         adr_s1_q <= word_address_lines;
         adr_s2_q <= adr_s1_q;
      end
   end

   // one character per rising edge of the synchronised strobe
   wire       chr_take = vld_s2_q & ~vld_s3_q;
   wire [6:0] chr      = chr_s2_q[6:0];
   wire       chr_odd  = ^chr_s2_q;

   // ==========================================
   // memory image
   reg [`CTPIL_DATA_W-1:0] image_mem [0:4095];
   reg [`CTPIL_DATA_W-1:0] rd_q;
   reg                     wr_en;

   // bits only ever set: a fresh image is all zero, writes OR in ones
   integer i;
   initial
   begin
      for (i = 0; i < 4096; i = i + 1)
         image_mem[i] = 4'h0; // see R15
   end

   // ==========================================
   // parser
   reg [2:0]  state_q;
   reg [3:0]  shift_q;
   reg [2:0]  nbits_q;
   reg [11:0] addr_q;
   reg [4:0]  rub_q;

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q      <= S_SEEK;
         shift_q      <= 4'h0;
         nbits_q      <= 3'h0;
         rub_q        <= 5'h00;
         words_loaded <= 13'h0000;
         load_done    <= 1'b0;
         format_error <= 1'b0;
         count_error  <= 1'b0;
         parity_error <= 1'b0;
         wr_en        <= 1'b0;
      end
      else
      begin
         wr_en <= 1'b0;
         if (chr_take && par_s2_q && chr_odd)
            parity_error <= 1'b1; // see R17
         if (chr_take)
         begin
            case (state_q)
               S_SEEK:
               begin
                  // filler, comments and line ends skipped until word-start
                  if (chr == `CTPIL_CH_START)
                  begin
                     state_q <= S_WORD; // see R4
                     nbits_q <= 3'h0;
                     shift_q <= 4'h0;
                     rub_q   <= 5'h00;
                  end
                  else if (chr == `CTPIL_CH_RUBOUT)
                  begin
                     // count a trailer run once data has been seen; see R1, R8
                     if (rub_q != `CTPIL_MIN_RUBOUTS)
                        rub_q <= rub_q + 5'h01;
                     if (rub_q == `CTPIL_MIN_RUBOUTS - 5'h01 && words_loaded != 13'h0000)
                     begin
                        state_q   <= S_DONE;
                        load_done <= 1'b1;
                        if (words_loaded != `CTPIL_WORDS)
                           count_error <= 1'b1; // see R16
                     end
                  end
                  else
                     rub_q <= 5'h00; // see R3, R7
               end
               S_WORD:
               begin
                  if (chr == `CTPIL_CH_RUBOUT)
                  begin
                     state_q <= S_SEEK; // partial word dropped; see R11
                     nbits_q <= 3'h0;
                  end
                  else if (is_level(chr) && nbits_q != `CTPIL_BITS_PER_WORD)
                  begin
                     // first level character lands in the top bit; see R5, R9
                     shift_q <= {shift_q[2:0], (chr == `CTPIL_CH_HIGH)};
                     nbits_q <= nbits_q + 3'h1;
                  end
                  else if (chr == `CTPIL_CH_FINISH && nbits_q == `CTPIL_BITS_PER_WORD)
                  begin
                     state_q <= S_SEEK; // see R6
                     if (words_loaded == `CTPIL_WORDS)
                        count_error <= 1'b1; // see R16
                     else
                     begin
                        wr_en        <= 1'b1;
                        words_loaded <= words_loaded + 13'h0001; // see R2
                     end
                  end
                  else
                  begin
                     format_error <= 1'b1; // see R10, R16
                     state_q      <= S_SEEK;
                  end
               end
               S_DONE:
                  state_q <= S_DONE;
               default:
                  state_q <= S_SEEK;
            endcase
         end
      end
   end

   // commit a finished word at the next address
   always @(posedge core_clk)
   begin
      if (wr_en)
         image_mem[addr_q] <= image_mem[addr_q] | shift_q; // see R2, R15
   end

   // address advances after each commit
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
         addr_q <= 12'h000;
      else if (wr_en)
         addr_q <= addr_q + 12'h001;
   end

   // ==========================================
   // read port
   always @(posedge core_clk)
   begin
      rd_q <= image_mem[adr_s2_q];
   end

   // outputs driven only with both selects low
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         memory_outputs    <= 4'h0;
         memory_outputs_oe <= 4'h0;
      end
      else
      begin
         memory_outputs    <= rd_q; // see R13
         memory_outputs_oe <= (cs_s2_q == 2'h0) ? 4'hF : 4'h0; // see R14
      end
   end
endmodule // ctpil_loader

/* ctpil_loader_test.sv */
// self-checking bench for the tape image loader
module ctpil_loader_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // clock, stimulus signals and design
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        parity_check_en = 1'b0;
   logic        chip_select_first_low = 1'b1;
   logic        chip_select_second_low = 1'b1;
   logic [11:0] word_address_lines = 12'h000;
   logic [7:0]  char_data;
   logic        char_valid, load_done, format_error, count_error, parity_error;
   logic [3:0]  memory_outputs, memory_outputs_oe;
   logic [12:0] words_loaded;
   logic [3:0]  img [0:5];
   logic [7:0]  rd_notes [$];
   logic [16:0] st_notes [$];
   int          err_total = 0;
   int          comparisons = 0;
   event        rd_ev, st_ev;
   always #50 core_clk = ~core_clk;
   ctpil_tape_src src (.core_clk(core_clk), .char_data(char_data), .char_valid(char_valid));
   ctpil_loader dut (
      .core_clk               (core_clk),
      .rst                    (rst),
      .char_data              (char_data),
      .char_valid             (char_valid),
      .parity_check_en        (parity_check_en),
      .word_address_lines     (word_address_lines),
      .chip_select_first_low  (chip_select_first_low),
      .chip_select_second_low (chip_select_second_low),
      .memory_outputs         (memory_outputs),
      .memory_outputs_oe      (memory_outputs_oe),
      .load_done              (load_done),
      .format_error           (format_error),
      .count_error            (count_error),
      .parity_error           (parity_error),
      .words_loaded           (words_loaded)
   );
   task automatic report_and_stop;
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [16:0] e, a);
      comparisons++;
      if (a !== e)
      begin
         err_total++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   // read driver and status snapshot, each noting its expectation
   task automatic rd(input logic [11:0] a, input logic s1, s2, input logic [3:0] e);
      word_address_lines = a;
      chip_select_first_low = s1;
      chip_select_second_low = s2;
      rd_notes.push_back((s1 | s2) ? 8'h00 : {4'hF, e});
      repeat (4) @(posedge core_clk);
      #10;
      ->rd_ev;
      @(posedge core_clk);
      #10;
   endtask
   task automatic st(input logic [16:0] e);
      st_notes.push_back(e);
      ->st_ev;
      @(posedge core_clk);
      #10;
   endtask
   // monitors take the oldest note when a result is due
   always @(rd_ev)
      chk(rd_notes.pop_front(), {memory_outputs_oe, memory_outputs & memory_outputs_oe});
   always @(st_ev)
      chk(st_notes.pop_front(), {load_done, format_error, count_error, parity_error, words_loaded});
   initial
   begin
      #2000000;
      err_total++;
      report_and_stop;
   end
   // ==========
   // main sequence
   initial
   begin
      void'($urandom(32'h9788C08A));
      repeat (10) @(posedge core_clk);
      #10;
      rst = 1'b0;
      src.rubouts(25);
      src.send(7'h0D);
      src.send(7'h46);
      src.send(7'h42);
      src.send(7'h50);
      src.send(7'h4E);
      src.rubouts(3);
      for (int i = 0; i < 6; i++)
      begin
         img[i] = 4'($urandom);
         src.word(img[i]);
         src.send(7'h0A);
      end
      st(17'h00006);
      parity_check_en = 1'b1;
      src.odd_par = 1'b1;
      src.send(7'h43);
      src.odd_par = 1'b0;
      st(17'h02006);
      src.send(7'h42);
      src.send(7'h4E);
      src.send(7'h43);
      st(17'h0A006);
      src.rubouts(25);
      st(17'h1E006);
      src.word(4'hF);
      st(17'h1E006);
      for (int i = 0; i < 6; i++)
         rd(12'(i), 1'b0, 1'b0, img[i]);
      rd(12'h006, 1'b0, 1'b0, 4'h0);
      rd({1'b1, 11'($urandom)}, 1'b0, 1'b0, 4'h0);
      rd(12'h000, 1'b1, 1'b0, 4'h0);
      rd(12'h000, 1'b0, 1'b1, 4'h0);
      report_and_stop;
   end
endmodule // ctpil_loader_test

/* ctpil_props.sv */
// property checker for the tape image loader ports
module ctpil_props (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        chip_select_first_low,
   input wire logic        chip_select_second_low,
   input wire logic [3:0]  memory_outputs_oe,
   input wire logic        load_done,
   input wire logic        format_error,
   input wire logic        count_error,
   input wire logic        parity_error,
   input wire logic [12:0] words_loaded
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // output enable and status relations
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   oe_float_a: assert property (
      (chip_select_first_low || chip_select_second_low) [*4] |=> memory_outputs_oe == 4'h0)
      else $error("outputs driven while deselected");
   oe_drive_a: assert property (
      (!chip_select_first_low && !chip_select_second_low) [*4] |=> memory_outputs_oe == 4'hF)
      else $error("outputs float while selected");
   word_step_a: assert property (
      words_loaded != $past(words_loaded) |-> words_loaded == $past(words_loaded) + 13'h1)
      else $error("word count moved by other than one");
   fmt_sticky_a: assert property (
      format_error |=> format_error)
      else $error("format flag dropped");
   par_sticky_a: assert property (
      !$fell(parity_error))
      else $error("parity flag dropped");
   done_word_a: assert property (
      $rose(load_done) |-> words_loaded != 13'h0000)
      else $error("done without any word");
   short_load_a: assert property (
      load_done && words_loaded != 13'h1000 |=> count_error)
      else $error("short load not flagged");
   done_frozen_a: assert property (
      load_done |=> $stable(words_loaded))
      else $error("words taken after done");
   cover property ($rose(load_done));
   cover property ($rose(format_error));
   cover property ($rose(parity_error));
endmodule // ctpil_props
bind ctpil_loader ctpil_props u_props (
   .core_clk               (core_clk),
   .rst                    (rst),
   .chip_select_first_low  (chip_select_first_low),
   .chip_select_second_low (chip_select_second_low),
   .memory_outputs_oe      (memory_outputs_oe),
   .load_done              (load_done),
   .format_error           (format_error),
   .count_error            (count_error),
   .parity_error           (parity_error),
   .words_loaded           (words_loaded)
);

/* ctpil_tape_src.sv */
// behavioural character source feeding the loader
module ctpil_tape_src (
   input wire logic  core_clk,
   output logic [7:0] char_data,
   output logic      char_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // character strobes
   bit odd_par = 1'b0;
   initial
   begin
      char_data = 8'h00;
      char_valid = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask
   // data settles before the strobe, line inverted once released
   task automatic send(input logic [6:0] c);
      char_data = {(^c) ^ odd_par, c};
      cyc(1);
      char_valid = 1'b1;
      cyc(3);
      char_valid = 1'b0;
      cyc(2);
      char_data = ~char_data;
      cyc(1);
   endtask
   task automatic rubouts(input int n);
      repeat (n) send(7'h7F);
   endtask
   // start, four levels from the top bit, finish
   task automatic word(input logic [3:0] w);
      send(7'h42);
      for (int i = 3; i >= 0; i--)
         send(w[i] ? 7'h50 : 7'h4E);
      send(7'h46);
   endtask
endmodule // ctpil_tape_src
